// File: verilog/sdl_host.sv
// Loader host: word FIFO, serial clock divider and shift sequencer
`timescale 1ns/1ps
module sdl_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr;
        logic [PTR_W-1:0] rd;
        logic [PTR_W:0] count;
    } sdl_fifo_s;

    sdl_fifo_s st_q;
    sdl_fifo_s st_d;
    logic push;
    logic pop;

    function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
        next_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
    endfunction

    assign in_ready = (st_q.count != (PTR_W + 1)'(DEPTH));
    assign out_valid = (st_q.count != '0);
    assign out_data = st_q.mem[st_q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr] = in_data;
            st_d.wr = next_ptr(st_q.wr);
        end
        if (pop) begin
            st_d.rd = next_ptr(st_q.rd);
        end
        if (push && !pop) begin
            st_d.count = st_q.count + 1'b1;
        end else if (pop && !push) begin
            st_d.count = st_q.count - 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

module sdl_host (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Word requests: data plus update-after-load flag
    input wire logic [sdl_pkg::WORD_W-1:0] word_data,
    input wire logic word_update,
    input wire logic word_valid,
    output logic word_ready,
    // Clear request and status
    input wire logic clear_req,
    output logic busy,
    output logic [sdl_pkg::WORD_W-1:0] readback_word,
    // Link
    sdl_link_if.host_mp link
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sdl_pkg::sdl_host_state_e state;
        logic [1:0] div;
        logic sclk;
        logic sdi;
        logic ile_n;
        logic ole_n;
        logic clr_n;
        logic [sdl_pkg::WORD_W-1:0] shreg;
        logic [sdl_pkg::BIT_CNT_W-1:0] bitcnt;
        logic upd;
        logic clr_pend;
        logic sdo_s1;
        logic sdo_s2;
        logic [sdl_pkg::WORD_W-1:0] rdbk_sh;
        logic [sdl_pkg::WORD_W-1:0] rdbk;
    } sdl_host_s;

    sdl_host_s st_q;
    sdl_host_s st_d;
    logic [sdl_pkg::FIFO_W-1:0] fifo_out;
    logic fifo_valid;
    logic fifo_pop;
    logic fall;
    logic rise;

    // ------------------------------------------------------------
    // Word buffer
    // ------------------------------------------------------------
    // Drained only at idle strobe boundaries, so it backs up onto word_ready
    sdl_fifo #(
        .WIDTH(sdl_pkg::FIFO_W),
        .DEPTH(sdl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .in_data({word_update, word_data}),
        .in_valid(word_valid),
        .in_ready(word_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Link outputs only change at the falling strobe edge, keeping them
    // stable across every rising edge the devices sample on
    assign fall = st_q.sclk && (st_q.div == sdl_pkg::SCLK_HALF_LAST);
    assign rise = !st_q.sclk && (st_q.div == sdl_pkg::SCLK_HALF_LAST);
    assign fifo_pop = fall && (st_q.state == sdl_pkg::SDL_IDLE) && !st_q.clr_pend;

    always_comb begin
        st_d = st_q;
        st_d.sdo_s1 = link.cascade_serial_out;
        st_d.sdo_s2 = st_q.sdo_s1;
        if (clear_req) begin
            st_d.clr_pend = 1'b1;
        end
        if (st_q.div == sdl_pkg::SCLK_HALF_LAST) begin
            st_d.div = '0;
            st_d.sclk = !st_q.sclk;
        end else begin
            st_d.div = st_q.div + 1'b1;
        end
        // Bit leaving the far end, sampled just before the strobe moves it
        if (rise && (st_q.state == sdl_pkg::SDL_SHIFT)) begin
            st_d.rdbk_sh = {st_q.rdbk_sh[sdl_pkg::WORD_W-2:0], st_q.sdo_s2};
        end
        if (fall) begin
            case (st_q.state)
                sdl_pkg::SDL_IDLE: begin
                    if (st_q.clr_pend) begin
                        st_d.clr_n = 1'b0;
                        st_d.clr_pend = clear_req;
                        st_d.state = sdl_pkg::SDL_CLEAR;
                    end else if (fifo_valid) begin
                        st_d.shreg = fifo_out[sdl_pkg::WORD_W-1:0];
                        st_d.upd = fifo_out[sdl_pkg::UPD_BIT];
                        st_d.sdi = fifo_out[sdl_pkg::WORD_W-1]; // [R11]
                        st_d.ile_n = 1'b0; // [R01] [R08]
                        st_d.bitcnt = '0;
                        st_d.state = sdl_pkg::SDL_SHIFT;
                    end
                end
                sdl_pkg::SDL_SHIFT: begin
                    if (st_q.bitcnt == sdl_pkg::LAST_BIT) begin
                        st_d.ile_n = 1'b1; // [R10]
                        st_d.rdbk = st_q.rdbk_sh;
                        if (st_q.upd) begin
                            st_d.ole_n = 1'b0; // [R02] [R07] [R09] [R14]
                            st_d.state = sdl_pkg::SDL_XFER;
                        end else begin
                            st_d.state = sdl_pkg::SDL_IDLE; // [R06]
                        end
                    end else begin
                        st_d.shreg = {st_q.shreg[sdl_pkg::WORD_W-2:0], 1'b0};
                        st_d.sdi = st_q.shreg[sdl_pkg::WORD_W-2]; // [R03] [R11]
                        st_d.bitcnt = st_q.bitcnt + 1'b1;
                    end
                end
                sdl_pkg::SDL_XFER: begin
                    st_d.ole_n = 1'b1; // [R14]
                    st_d.state = sdl_pkg::SDL_IDLE;
                end
                sdl_pkg::SDL_CLEAR: begin
                    st_d.clr_n = 1'b1;
                    st_d.state = sdl_pkg::SDL_IDLE;
                end
                default: begin
                    st_d.state = sdl_pkg::SDL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
            st_q.state <= sdl_pkg::SDL_IDLE;
            st_q.ile_n <= 1'b1;
            st_q.ole_n <= 1'b1;
            st_q.clr_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.sclk = st_q.sclk;
    assign link.sdi = st_q.sdi;
    assign link.input_latch_enable_n = st_q.ile_n;
    assign link.output_latch_enable_n = st_q.ole_n;
    assign link.clear_n = st_q.clr_n;
    assign busy = (st_q.state != sdl_pkg::SDL_IDLE) || fifo_valid || st_q.clr_pend;
    assign readback_word = st_q.rdbk;
endmodule

// File: inc/sdl_pkg.sv
// Shared constants and types of the serial converter loader link
// Function
// [R01] Input latch loads only while its enable is low
// [R02] Converter latch loads only while its enable is low
// [R03] Serial clock strobes data into enabled latches
// [R04] Clear zeroes both latches regardless of clock
// [R05] Serial output follows the input latch
// [R06] Chain of N needs 16N clocks per load
// [R07] Chain updates together with one shared enable
// [R08] Parallel devices load within sixteen clocks each
// [R09] Output enables driven together or one by one
// [R10] Controls active low; latches hold when disabled
// [R11] Words are straight binary, most significant first
// [R12] Cleared converter latch holds code zero
// [R13] Input latch shifts; output is shifted-out MSB
// [R14] Enables stable per strobe; no update mid-shift
package sdl_pkg;
    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int BIT_CNT_W = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = WORD_W + 1;
    localparam int UPD_BIT = WORD_W;
    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [WORD_W-1:0] CLEAR_CODE = 16'h0000;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hf;
    // Serial clock half period in mclk cycles; 4 leaves room for the sync delay
    localparam logic [1:0] SCLK_HALF_LAST = 2'h3;
    // ------------------------------------------------------------
    // Host sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SDL_IDLE,
        SDL_SHIFT,
        SDL_XFER,
        SDL_CLEAR
    } sdl_host_state_e;
endpackage

// File: inc/sdl_link_if.sv
// Serial link between the loader host and one converter loader
`timescale 1ns/1ps
interface sdl_link_if;
    logic sclk;
    logic sdi;
    logic input_latch_enable_n;
    logic output_latch_enable_n;
    logic clear_n;
    logic cascade_serial_out;

    modport dev_mp (
        input sclk,
        input sdi,
        input input_latch_enable_n,
        input output_latch_enable_n,
        input clear_n,
        output cascade_serial_out
    );

    modport host_mp (
        output sclk,
        output sdi,
        output input_latch_enable_n,
        output output_latch_enable_n,
        output clear_n,
        input cascade_serial_out
    );
endinterface

// File: verilog/sdl_device.sv
// Converter-side loader: input shift latch and converter latch on the link clock
`timescale 1ns/1ps
module sdl_device (
    // Link
    sdl_link_if.dev_mp link,
    // Converter side
    output logic [sdl_pkg::WORD_W-1:0] dac_code
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [sdl_pkg::WORD_W-1:0] shift;
        logic [sdl_pkg::WORD_W-1:0] code;
    } sdl_dev_s;

    sdl_dev_s st_q;
    sdl_dev_s st_d;

    always_comb begin
        st_d = st_q;
        if (!link.input_latch_enable_n) begin
            st_d.shift = {st_q.shift[sdl_pkg::WORD_W-2:0], link.sdi}; // [R01] [R11] [R13]
        end
        // Takes the word as it stood before this strobe
        if (!link.output_latch_enable_n) begin
            st_d.code = st_q.shift; // [R02]
        end
    end

    // Clear is the only reset this side has
    always_ff @(posedge link.sclk or negedge link.clear_n) begin
        if (!link.clear_n) begin
            st_q.shift <= sdl_pkg::CLEAR_CODE; // [R04] [R10]
            st_q.code <= sdl_pkg::CLEAR_CODE; // [R12]
        end else begin
            st_q <= st_d; // [R03] [R10]
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.cascade_serial_out = st_q.shift[sdl_pkg::WORD_W-1]; // [R05] [R13]
    assign dac_code = st_q.code;
endmodule

// File: verif/sdl_link_chk.sv
// Timing checker of the loader link seen at the interface signals
`timescale 1ns/1ps
module sdl_link_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Link
    input wire logic sclk,
    input wire logic sdi,
    input wire logic input_latch_enable_n,
    input wire logic output_latch_enable_n,
    input wire logic clear_n,
    input wire logic cascade_serial_out
);
    // ------------------------------------------------------------
    // Helper: length of the current shift frame in mclk cycles
    // ------------------------------------------------------------
    // A counter, since a repetition of 128 would choke the tools
    logic [7:0] low_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            low_q <= 8'h00;
        end else begin
            low_q <= input_latch_enable_n ? 8'h00 : low_q + 8'h01;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    enable_excl_a: assert property (
        input_latch_enable_n || output_latch_enable_n) else $error("both enables low");
    sclk_half_a: assert property (
        $rose(sclk) |-> sclk[*4] ##1 !sclk) else $error("serial clock high phase wrong");
    link_edge_a: assert property (
        !$stable({sdi, input_latch_enable_n, output_latch_enable_n, clear_n}) |-> $fell(sclk))
        else $error("link output moved off a clock fall");
    clear_len_a: assert property (
        $fell(clear_n) |-> !clear_n[*8] ##1 clear_n) else $error("clear pulse length wrong");
    update_len_a: assert property (
        $fell(output_latch_enable_n) |-> !output_latch_enable_n[*8] ##1 output_latch_enable_n)
        else $error("update pulse length wrong");
    frame_len_a: assert property (
        $rose(input_latch_enable_n) |-> low_q == 8'h80) else $error("frame not sixteen strobes");
    frame_gap_a: assert property (
        $rose(input_latch_enable_n) |-> input_latch_enable_n[*5]) else $error("frame gap short");
    cascade_edge_a: assert property (
        !$stable(cascade_serial_out) |-> (sclk && !input_latch_enable_n) || !clear_n)
        else $error("serial output moved without a strobe");
    clear_idle_a: assert property (
        !clear_n |-> input_latch_enable_n && output_latch_enable_n)
        else $error("clear during a transfer");
endmodule

// File: verif/testbench.sv
// Testbench of host and two chained converter loaders
`timescale 1ns/1ps
module testbench;
    logic mclk;
    logic reset;
    logic [15:0] word_data;
    logic word_update;
    logic word_valid;
    logic word_ready;
    logic clear_req;
    logic busy;
    logic [15:0] readback_word;
    logic [15:0] dac_a;
    logic [15:0] dac_b;
    int fail_count = 0;
    int n_tests = 0;
    sdl_link_if link();
    sdl_link_if link2();
    // ------------------------------------------------------------
    // Second loader takes the first one's serial output
    // ------------------------------------------------------------
    assign link2.sclk = link.sclk;
    assign link2.sdi = link.cascade_serial_out;
    assign link2.input_latch_enable_n = link.input_latch_enable_n;
    assign link2.output_latch_enable_n = link.output_latch_enable_n;
    assign link2.clear_n = link.clear_n;
    sdl_host sdl_host_inst (.mclk(mclk), .reset(reset), .word_data(word_data),
        .word_update(word_update), .word_valid(word_valid), .word_ready(word_ready),
        .clear_req(clear_req), .busy(busy), .readback_word(readback_word), .link(link));
    sdl_device sdl_device_inst (.link(link), .dac_code(dac_a));
    sdl_device sdl_device_inst2 (.link(link2), .dac_code(dac_b));
    sdl_link_chk sdl_link_chk_inst (.mclk(mclk), .reset(reset), .sclk(link.sclk),
        .sdi(link.sdi), .input_latch_enable_n(link.input_latch_enable_n),
        .output_latch_enable_n(link.output_latch_enable_n), .clear_n(link.clear_n),
        .cascade_serial_out(link.cascade_serial_out));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask
    task automatic results;
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic push(input logic [15:0] d, input logic u);
        @(negedge mclk);
        word_data = d;
        word_update = u;
        word_valid = 1'b1;
        while (word_ready !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        word_valid = 1'b0;
    endtask
    // Busy covers the update pulse too, so the wait past idle is only margin
    task automatic wait_idle;
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge mclk);
        // A host that never settles counts against the run
        if (busy !== 1'b0) fail_count++;
        repeat (24) @(negedge mclk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check("idle", {10'h000, link.sclk, link.input_latch_enable_n,
            link.output_latch_enable_n, link.clear_n, word_ready, busy}, 16'h001e);
        check("readback", readback_word, 16'h0000);
    endtask
    task automatic t_clear;
        @(negedge mclk);
        clear_req = 1'b1;
        @(negedge mclk);
        clear_req = 1'b0;
        wait_idle();
        check("clear a", dac_a, 16'h0000);
        check("clear b", dac_b, 16'h0000);
    endtask
    task automatic t_chain;
        push(16'ha5c3, 1'b0);
        push(16'h0f01, 1'b1);
        wait_idle();
        check("chain a", dac_a, 16'h0f01);
        check("chain b", dac_b, 16'ha5c3);
        check("readback", readback_word, 16'ha5c3);
    endtask
    task automatic t_hold;
        push(16'h7ffe, 1'b0);
        wait_idle();
        check("hold a", dac_a, 16'h0f01);
        check("hold b", dac_b, 16'ha5c3);
        check("readback", readback_word, 16'h0f01);
        push(16'h8001, 1'b1);
        wait_idle();
        check("load a", dac_a, 16'h8001);
        check("load b", dac_b, 16'h7ffe);
    endtask
    task automatic t_fill;
        int n;
        n = 0;
        @(negedge mclk);
        word_valid = 1'b1;
        word_update = 1'b1;
        while (word_ready === 1'b1 && n < 12) begin
            word_data = 16'h1000 + 16'(n);
            @(negedge mclk);
            n++;
        end
        word_valid = 1'b0;
        // One word may already have left for the link during the fill
        check("fill count", {15'h0000, n == 8 || n == 9}, 16'h0001);
        wait_idle();
        check("ready", {15'h0000, word_ready}, 16'h0001);
        check("fill a", dac_a, 16'h1000 + 16'(n - 1));
        check("fill b", dac_b, 16'h1000 + 16'(n - 2));
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #400000;
        fail_count++;
        results();
    end
    initial begin
        reset = 1'b1;
        word_data = 16'h0000;
        word_update = 1'b0;
        word_valid = 1'b0;
        clear_req = 1'b0;
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        t_reset();
        t_clear();
        t_chain();
        t_hold();
        t_fill();
        t_clear();
        results();
    end
endmodule
